// >>> interp_defines.svh
// constants for the linear function interpolator: register map, fields,
// reset values and timing figures; included by the top module and the testbench
`ifndef INTERP_DEFINES_SVH
`define INTERP_DEFINES_SVH

`define CLK_PERIOD_NS  10
`define DRUM_WORD_NS   6100
`define PROC_ONE_NS    120000
`define SWEEP_WORDS    16344

`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_SWEEP      8'h08
`define REG_RESULT     8'h0C
`define REG_DRUM       8'h10

`define CTRL_RUN       0
`define CTRL_IDX_LO    1
`define CTRL_RUN_RST   1'h1
`define CTRL_IDX_RST   2'h0
`define STAT_BUSY      0
`define STAT_FAIL      1

`define CW_NV_LO       0
`define CW_IX_X        2
`define CW_IX_ANS      5
`define WORD_FLAG      10
`define ARG_MSB        23
`define ARG_LSB        10

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// >>> interp_pkg.sv
// types shared by the interpolator top and its arithmetic stage
// assumes nothing beyond a SystemVerilog compiler
package interp_pkg;

  typedef enum logic [2:0] {
    S_SEEK  = 3'b000,
    S_ARG   = 3'b001,
    S_TAB   = 3'b010,
    S_ANS   = 3'b011,
    S_CALC  = 3'b100,
    S_WRITE = 3'b101
  } state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [10:0] addr;
    logic [23:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic       sgn;
    logic [2:0] ival;
    logic [9:0] incr;
  } arg_t;

endpackage

// >>> interp_lerp.sv
// one straight-line interpolation step between two table points
// assumes the caller registers the results; purely combinational
`timescale 1ns/100ps
module interp_lerp
  import interp_pkg::*;
#(
  parameter int W  = 14,
  parameter int FW = 10
) (
  input  wire logic [W-1:0]  lo_i,
  input  wire logic [W-1:0]  hi_i,
  input  wire logic [FW-1:0] frac_i,
  output logic      [W-1:0]  r14_o,
  output logic      [W+1:0]  r16_o
);

  localparam int PW = W + FW + 2;

  if (FW < 2 || W < 4) begin : g_bad
    $error("interp_lerp: widths too small");
  end

  logic signed [W:0]    diff;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] sum;
  logic signed [PW-1:0] rnd;

  // lower point plus increment times the span
  assign diff = $signed({1'b0, hi_i}) - $signed({1'b0, lo_i});
  assign prod = diff * $signed({1'b0, frac_i});
  assign sum  = $signed({2'b00, lo_i, FW'(0)}) + prod;
  // intermediate rounds to W bits, never exceeds the larger point
  assign rnd  = sum + $signed(PW'(1 << (FW - 1)));
  assign r14_o = rnd[W+FW-1:FW];
  // output keeps two more bits, truncated
  assign r16_o = sum[W+FW-1:FW-2];

endmodule // interp_lerp

// >>> linear_function_interpolator.sv
// linear function interpolator: walks the drum table field, fetches
// arguments from and stores answers to the shared core data memory.
// assumes a same-clock arbiter answering each request with a grant pulse
// and a drum word that stays put while drum_addr_o is unchanged.
// Function
// - table words are positive 10-bit fractions
// - internal steps round to 14 bits
// - answers are 16-bit truncated fractions
// - straight-line interpolation over equal intervals
// - one-variable function done within 120 us
// - argument takes upper 14 memory bits
// - answer written at answer address
// - drum word: flag plus 10-bit field
// - word meaning follows its band position
// - control word gives variables and indexing
// - index 0-3 added to chosen addresses
// - one variable: nine table words
// - two variables 9x9, three 9x9x9
// - argument: sign, interval, 10-bit increment
// - negative argument becomes zero
// - argument address comes from drum word
// - fixed sequence, paced by drum words
// - whole 16,344-word field every 0.1 s
// - data moves only through data memory; answers are also readable here over REG_RESULT
// - one drum word per 6.1 us
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "interp_defines.svh"
module linear_function_interpolator
  import interp_pkg::*;
#(
  parameter int WORD_CYCLES = `DRUM_WORD_NS / `CLK_PERIOD_NS,
  parameter int SWEEP_WORDS = `SWEEP_WORDS,
  parameter int PROC_CYCLES = `PROC_ONE_NS / `CLK_PERIOD_NS
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        axi_awvalid_i,
  output logic             axi_awready_o,
  input  wire logic [7:0]  axi_awaddr_i,
  input  wire logic        axi_wvalid_i,
  output logic             axi_wready_o,
  input  wire logic [31:0] axi_wdata_i,
  input  wire logic [3:0]  axi_wstrb_i,
  output logic             axi_bvalid_o,
  input  wire logic        axi_bready_i,
  output logic [1:0]       axi_bresp_o,
  input  wire logic        axi_arvalid_i,
  output logic             axi_arready_o,
  input  wire logic [7:0]  axi_araddr_i,
  output logic             axi_rvalid_o,
  input  wire logic        axi_rready_i,
  output logic [31:0]      axi_rdata_o,
  output logic [1:0]       axi_rresp_o,
  output mem_req_t         mem_o,
  input  wire logic        mem_gnt_i,
  input  wire logic [23:0] mem_rdata_i,
  output logic [13:0]      drum_addr_o,
  input  wire logic [10:0] drum_word_i
);

  localparam int WCW = $clog2(WORD_CYCLES);

  if (WORD_CYCLES < 16 || SWEEP_WORDS > 16384 || SWEEP_WORDS < 1024) begin : g_bad
    $error("linear_function_interpolator: unsupported timing parameters");
  end

  logic        rst_q1_r;
  logic        rst_n;
  logic [10:0] dw_q1_r;
  logic [10:0] dw_r;
  logic [WCW-1:0] wcnt_r;
  logic [13:0] drum_addr_r;
  logic [15:0] sweep_r;
  logic        word_tick;
  state_t      state_r;
  logic [1:0]  nv_r;
  logic [3:0]  ixen_r;
  logic [1:0]  argn_r;
  logic [1:0]  tag_r;
  logic [3:0]  px_r;
  logic [3:0]  py_r;
  logic [3:0]  pz_r;
  logic [2:0]  step_r;
  logic [10:0] ans_addr_r;
  arg_t        arg_r [3];
  logic [9:0]  corner_r [8];
  logic [13:0] val_r [8];
  mem_req_t    mem_r;
  logic        run_r;
  logic [1:0]  idx_r;
  logic        fail_r;
  logic [15:0] result_r;
  logic        awready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        fail_ev;
  logic        tab_last;
  logic        wr_go;
  logic        rd_go;
  logic [1:0]  lj;
  logic [9:0]  lfrac;
  logic [13:0] l14;
  logic [15:0] l16;
  logic [10:0] arg_addr;
  logic [3:0]  ix;
  logic [3:0]  iy;
  logic [3:0]  iz;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n    <= rst_q1_r;
    end
  end

  // drum read-out is asynchronous to the core clock; it settles long before use
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dw_q1_r <= 11'h000;
      dw_r    <= 11'h000;
    end else if (ce_i) begin
      dw_q1_r <= drum_word_i;
      dw_r    <= dw_q1_r;
    end
  end

  // drum word clock and sweep through the whole table field
  assign word_tick = ce_i && (wcnt_r == WCW'(WORD_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_r      <= '0;
      drum_addr_r <= 14'h0000;
      sweep_r     <= 16'h0000;
    end else if (ce_i) begin
      wcnt_r <= word_tick ? '0 : wcnt_r + 1'b1;
      if (word_tick) begin
        if (drum_addr_r == 14'(SWEEP_WORDS - 1)) begin
          drum_addr_r <= 14'h0000;
          sweep_r     <= sweep_r + 16'h0001;
        end else begin
          drum_addr_r <= drum_addr_r + 14'h0001;
        end
      end
    end
  end

  // field of the current word, indexed when its enable bit is set
  assign arg_addr = {1'b0, dw_r[9:0]} + ((state_r == S_ARG && ixen_r[argn_r]) ||
                    (state_r == S_ANS && ixen_r[3]) ? {9'h000, idx_r} : 11'h000);
  assign ix = {1'b0, arg_r[0].ival};
  assign iy = {1'b0, arg_r[1].ival};
  assign iz = {1'b0, arg_r[2].ival};
  assign tab_last = (px_r == 4'h8) && (nv_r < 2'h2 || py_r == 4'h8) &&
                    (nv_r < 2'h3 || pz_r == 4'h8);
  // an argument still unserved when the next word comes is a failure
  assign fail_ev = word_tick && mem_r.req && !mem_gnt_i &&
                   (state_r == S_ARG || state_r == S_TAB);

  // wired sequence: control, argument addresses, table, answer
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= S_SEEK;
      nv_r       <= 2'h1;
      ixen_r     <= 4'h0;
      argn_r     <= 2'h0;
      px_r       <= 4'h0;
      py_r       <= 4'h0;
      pz_r       <= 4'h0;
      step_r     <= 3'h0;
      ans_addr_r <= 11'h000;
    end else if (ce_i) begin
      if (fail_ev) begin
        state_r <= S_SEEK;
      end else begin
        case (state_r)
          S_SEEK: begin
            // flagged control word with one to three variables
            if (word_tick && run_r && dw_r[`WORD_FLAG] && dw_r[`CW_NV_LO+1:`CW_NV_LO] != 2'h0) begin
              nv_r    <= dw_r[`CW_NV_LO+1:`CW_NV_LO];
              ixen_r  <= dw_r[`CW_IX_ANS:`CW_IX_X];
              argn_r  <= 2'h0;
              state_r <= S_ARG;
            end
          end
          S_ARG: begin
            if (word_tick) begin
              argn_r <= argn_r + 2'h1;
              if (argn_r + 2'h1 == nv_r) begin
                px_r    <= 4'h0;
                py_r    <= 4'h0;
                pz_r    <= 4'h0;
                state_r <= S_TAB;
              end
            end
          end
          S_TAB: begin
            if (word_tick) begin
              if (tab_last) begin
                state_r <= S_ANS;
              end else if (px_r == 4'h8) begin
                px_r <= 4'h0;
                if (py_r == 4'h8) begin
                  py_r <= 4'h0;
                  pz_r <= pz_r + 4'h1;
                end else begin
                  py_r <= py_r + 4'h1;
                end
              end else begin
                px_r <= px_r + 4'h1;
              end
            end
          end
          S_ANS: begin
            if (word_tick) begin
              ans_addr_r <= arg_addr;
              step_r     <= 3'h0;
              state_r    <= S_CALC;
            end
          end
          S_CALC: begin
            step_r <= step_r + 3'h1;
            if (step_r == 3'h6) begin
              state_r <= S_WRITE;
            end
          end
          S_WRITE: begin
            if (mem_gnt_i) begin
              state_r <= S_SEEK;
            end
          end
          default: state_r <= S_SEEK;
        endcase
      end
    end
  end

  // data memory is the only argument path; answers go to it and to result_r
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_r <= '0;
      tag_r <= 2'h0;
    end else if (ce_i) begin
      if (fail_ev) begin
        mem_r.req <= 1'b0;
      end else if (state_r == S_ARG && word_tick) begin
        mem_r <= '{req: 1'b1, we: 1'b0, addr: arg_addr, wdata: 24'h00_0000};
        tag_r <= argn_r;
      end else if (state_r == S_CALC && step_r == 3'h6) begin
        mem_r <= '{req: 1'b1, we: 1'b1, addr: ans_addr_r, wdata: {l16, 8'h00}};
      end else if (mem_gnt_i) begin
        mem_r.req <= 1'b0;
      end
    end
  end

  // arguments: upper 14 bits, negative ones forced to zero
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        arg_r[i] <= '0;
      end
    end else if (ce_i) begin
      if (state_r == S_SEEK) begin
        for (int i = 0; i < 3; i++) begin
          arg_r[i] <= '0;
        end
      end else if (mem_gnt_i && mem_r.req && !mem_r.we) begin
        arg_r[tag_r] <= mem_rdata_i[`ARG_MSB] ? '0 : {1'b0, mem_rdata_i[`ARG_MSB-1:`ARG_LSB]};
      end
    end
  end

  // keep only the bracketing points; unused dimensions sit at interval 0
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        corner_r[i] <= 10'h000;
      end
    end else if (ce_i) begin
      if (state_r == S_SEEK) begin
        for (int i = 0; i < 8; i++) begin
          corner_r[i] <= 10'h000;
        end
      end else if (state_r == S_TAB && word_tick &&
                   (px_r == ix || px_r == ix + 4'h1) &&
                   (py_r == iy || py_r == iy + 4'h1) &&
                   (pz_r == iz || pz_r == iz + 4'h1)) begin
        corner_r[{pz_r != iz, py_r != iy, px_r != ix}] <= dw_r[9:0];
      end
    end
  end

  // seven steps: four along x, two along y, one along z
  always_comb begin
    lj    = (step_r == 3'h6) ? 2'h0 : step_r[1:0];
    lfrac = arg_r[0].incr;
    if (step_r == 3'h6) begin
      lfrac = arg_r[2].incr;
    end else if (step_r[2]) begin
      lfrac = arg_r[1].incr;
    end
  end

  interp_lerp #(
    .W  (14),
    .FW (10)
  ) u_lerp (
    .lo_i   (val_r[{lj, 1'b0}]),
    .hi_i   (val_r[{lj, 1'b1}]),
    .frac_i (lfrac),
    .r14_o  (l14),
    .r16_o  (l16)
  );

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        val_r[i] <= 14'h0000;
      end
      result_r <= 16'h0000;
    end else if (ce_i) begin
      if (state_r == S_ANS && word_tick) begin
        for (int i = 0; i < 8; i++) begin
          val_r[i] <= {corner_r[i], 4'h0};
        end
      end else if (state_r == S_CALC) begin
        if (step_r == 3'h6) begin
          result_r <= l16;
        end else begin
          val_r[lj] <= l14;
        end
      end
    end
  end

  // register slave; waits for address and data together
  assign wr_go = ce_i && axi_awvalid_i && axi_wvalid_i && !bvalid_r && !awready_r;
  assign rd_go = ce_i && axi_arvalid_i && !rvalid_r && !arready_r;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
      run_r     <= `CTRL_RUN_RST;
      idx_r     <= `CTRL_IDX_RST;
      fail_r    <= 1'b0;
    end else if (ce_i) begin
      awready_r <= wr_go;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (axi_awaddr_i == `REG_CTRL || axi_awaddr_i == `REG_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
        if (axi_awaddr_i == `REG_CTRL && axi_wstrb_i[0]) begin
          run_r <= axi_wdata_i[`CTRL_RUN];
          idx_r <= axi_wdata_i[`CTRL_IDX_LO+1:`CTRL_IDX_LO];
        end
      end else if (axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
      // a failure in the clearing cycle still sticks
      if (fail_ev) begin
        fail_r <= 1'b1;
      end else if (wr_go && axi_awaddr_i == `REG_STATUS && axi_wstrb_i[0] && axi_wdata_i[`STAT_FAIL]) begin
        fail_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `RESP_OKAY;
    end else if (ce_i) begin
      arready_r <= rd_go;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= `RESP_OKAY;
        case (axi_araddr_i)
          `REG_CTRL:   rdata_r <= {29'h0000_0000, idx_r, run_r};
          `REG_STATUS: rdata_r <= {30'h0000_0000, fail_r, state_r != S_SEEK};
          `REG_SWEEP:  rdata_r <= {16'h0000, sweep_r};
          `REG_RESULT: rdata_r <= {16'h0000, result_r};
          `REG_DRUM:   rdata_r <= {18'h0_0000, drum_addr_r};
          default: begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RESP_SLVERR;
          end
        endcase
      end else if (axi_rready_i) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign axi_awready_o = awready_r;
  assign axi_wready_o  = awready_r;
  assign axi_bvalid_o  = bvalid_r;
  assign axi_bresp_o   = bresp_r;
  assign axi_arready_o = arready_r;
  assign axi_rvalid_o  = rvalid_r;
  assign axi_rdata_o   = rdata_r;
  assign axi_rresp_o   = rresp_r;
  assign mem_o         = mem_r;
  assign drum_addr_o   = drum_addr_r;

  // checking helpers: cycles since the last word and since function start
  logic [15:0] gap_r;
  logic        gap_ok_r;
  logic [15:0] proc_r;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gap_r    <= 16'h0000;
      gap_ok_r <= 1'b0;
      proc_r   <= 16'h0000;
    end else if (ce_i) begin
      gap_r    <= word_tick ? 16'h0000 : gap_r + 16'h0001;
      gap_ok_r <= gap_ok_r | word_tick;
      proc_r   <= (state_r == S_SEEK) ? 16'h0000 : proc_r + 16'h0001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  AST_WORD_PERIOD: assert property (word_tick && gap_ok_r |-> gap_r == 16'(WORD_CYCLES - 1))
    else $error("drum word period wrong");
  AST_SWEEP_WRAP: assert property (word_tick && drum_addr_r == 14'(SWEEP_WORDS - 1)
    |=> drum_addr_r == 14'h0000 && sweep_r == $past(sweep_r) + 16'h0001)
    else $error("table field sweep did not wrap");
  AST_ARG_UPPER: assert property (ce_i && mem_gnt_i && mem_r.req && !mem_r.we && !mem_rdata_i[23]
    |=> arg_r[$past(tag_r)] == {1'b0, $past(mem_rdata_i[22:10])})
    else $error("argument not taken from upper bits");
  AST_ARG_NEG: assert property (ce_i && mem_gnt_i && mem_r.req && !mem_r.we && mem_rdata_i[23]
    |=> arg_r[$past(tag_r)] == '0)
    else $error("negative argument not zeroed");
  AST_WRITE_ADDR: assert property (mem_r.req && mem_r.we |-> state_r == S_WRITE && mem_r.addr == ans_addr_r)
    else $error("result written to wrong address");
  AST_ANS_INDEX: assert property (state_r == S_ANS && word_tick |=> ans_addr_r ==
    {1'b0, $past(dw_r[9:0])} + ($past(ixen_r[3]) ? {9'h000, $past(idx_r)} : 11'h000))
    else $error("answer address indexing wrong");
  AST_ARG_COUNT: assert property (state_r == S_ARG && word_tick && !fail_ev && argn_r + 2'h1 == nv_r
    |=> state_r == S_TAB ##1 argn_r == $past(nv_r, 2))
    else $error("argument word count differs from control word");
  AST_RESULT_SPAN: assert property (ce_i && state_r == S_CALC && step_r == 3'h6 |=>
    result_r >= {(val_r[0] < val_r[1] ? val_r[0] : val_r[1]), 2'b00} &&
    result_r <= {(val_r[0] < val_r[1] ? val_r[1] : val_r[0]), 2'b00})
    else $error("result outside bracketing points");
  AST_ONE_VAR_TIME: assert property (state_r == S_CALC && step_r == 3'h6 && nv_r == 2'h1
    |-> proc_r <= 16'(PROC_CYCLES))
    else $error("one-variable process too slow");

  COV_ONE_VAR: cover property (state_r == S_WRITE && mem_gnt_i && nv_r == 2'h1);
  COV_THREE_VAR: cover property (state_r == S_WRITE && mem_gnt_i && nv_r == 2'h3);
  COV_FAIL: cover property (fail_ev);
  COV_REG_WRITE: cover property (wr_go && axi_awaddr_i == `REG_CTRL);

endmodule // linear_function_interpolator

// >>> mem_model.sv
// partner: shared data memory behind a grant arbiter, plus the drum band store
// assumes one request at a time, held until granted, on the core clock
`timescale 1ns/100ps
module mem_model
  import interp_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire mem_req_t    mem_i,
  input  wire logic        stall_i,
  output logic             mem_gnt_o,
  output logic [23:0]      mem_rdata_o,
  input  wire logic [13:0] drum_addr_i,
  output logic [10:0]      drum_word_o
);
  logic [23:0] mem [0:2047];
  logic [10:0] rom [0:1023];
  logic [1:0]  wait_r;
  int          wr_cnt = 0;
  initial begin
    foreach (mem[i]) mem[i] = 24'h00_0000;
    foreach (rom[i]) rom[i] = 11'h000;
    mem_gnt_o = 1'b0;
    mem_rdata_o = 24'h00_0000;
    wait_r = 2'h0;
  end
  assign drum_word_o = rom[drum_addr_i[9:0]];
  // higher-ranked users modelled as a two-cycle hold-off; stall_i starves us
  always @(posedge core_clk_i) begin
    mem_gnt_o <= 1'b0;
    // read data toggles except on a read grant so stale values never look valid
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_i.req && !mem_gnt_o && !stall_i) begin
      wait_r <= wait_r + 2'h1;
      if (wait_r == 2'h2) begin
        wait_r <= 2'h0;
        mem_gnt_o <= 1'b1;
        if (mem_i.we) begin
          mem[mem_i.addr] <= mem_i.wdata;
          wr_cnt <= wr_cnt + 1;
        end else begin
          mem_rdata_o <= mem[mem_i.addr];
        end
      end
    end
  end
endmodule // mem_model

// >>> linear_function_interpolator_tb.sv
// testbench: three one-variable functions and one of three variables on a shortened drum field
// assumes mem_model answers the data port; registers reached over AXI4-Lite
`timescale 1ns/100ps
`include "interp_defines.svh"
module linear_function_interpolator_tb
  import interp_pkg::*;
;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, stall, ce;
  logic        awready, wready, bvalid, arready, rvalid, gnt;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  mem_req_t    mem;
  logic [23:0] mrdata;
  logic [13:0] daddr;
  logic [10:0] dword;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  // 120 us scaled to a 16-cycle drum word, rounded up
  linear_function_interpolator #(.WORD_CYCLES(16), .SWEEP_WORDS(1024), .PROC_CYCLES(315))
    linear_function_interpolator_inst (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .axi_awvalid_i(awvalid), .axi_awready_o(awready), .axi_awaddr_i(awaddr), .axi_wvalid_i(wvalid),
    .axi_wready_o(wready), .axi_wdata_i(wdata), .axi_wstrb_i(4'hf), .axi_bvalid_o(bvalid),
    .axi_bready_i(bready), .axi_bresp_o(bresp), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
    .axi_araddr_i(araddr), .axi_rvalid_o(rvalid), .axi_rready_i(rready), .axi_rdata_o(rdata),
    .axi_rresp_o(rresp), .mem_o(mem), .mem_gnt_i(gnt), .mem_rdata_i(mrdata),
    .drum_addr_o(daddr), .drum_word_i(dword));
  mem_model mem_model_inst (.core_clk_i(clk), .mem_i(mem), .stall_i(stall), .mem_gnt_o(gnt),
    .mem_rdata_o(mrdata), .drum_addr_i(daddr), .drum_word_o(dword));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      end_sim();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    rs = 2'bxx;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        break;
      end
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task rd_reg(input logic [7:0] a);
    rd = 32'hxxxx_xxxx;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        break;
      end
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task t_regs;
    rd_reg(`REG_CTRL);
    chk("ctrl reset", rd, 32'h0000_0001);
    wr_reg(`REG_CTRL, 32'h0000_0005);
    chk("ctrl write resp", rs, `RESP_OKAY);
    rd_reg(`REG_CTRL);
    chk("ctrl index", rd, 32'h0000_0005);
    wr_reg(`REG_SWEEP, 32'h0000_0007);
    chk("read-only write resp", rs, `RESP_SLVERR);
    rd_reg(8'h14);
    chk("unmapped rdata", rd, 32'h0000_0000);
    chk("unmapped resp", rs, `RESP_SLVERR);
  endtask
  task t_funcs;
    for (int n = 0; n < 20000 && mem_model_inst.wr_cnt < 4; n++) @(posedge clk);
    chk("answer f1", mem_model_inst.mem[20], 24'h57_8000);
    chk("answer f2", mem_model_inst.mem[21], 24'h19_0000);
    chk("answer f3", mem_model_inst.mem[24], 24'hCE_4000);
    chk("unindexed answer", mem_model_inst.mem[22], 24'h00_0000);
    chk("answer f4", mem_model_inst.mem[26], 24'h4E_C000);
    chk("argument kept", mem_model_inst.mem[5], 24'h28_03FF);
    rd_reg(`REG_RESULT);
    chk("result reg", rd, 32'h0000_4EC0);
  endtask
  task t_sweep;
    logic [13:0] prev;
    int          n;
    prev = daddr;
    for (n = 0; n < 20000 && !(daddr == 14'h0000 && prev != 14'h0000); n++) begin
      prev = daddr;
      @(posedge clk);
    end
    prev = daddr;
    @(posedge clk);
    for (n = 1; n < 20000 && !(daddr == 14'h0000 && prev != 14'h0000); n++) begin
      prev = daddr;
      @(posedge clk);
    end
    chk("sweep cycles", n, 16384);
    chk("writes per two sweeps", mem_model_inst.wr_cnt, 8);
    rd_reg(`REG_SWEEP);
    chk("sweep count", rd, 32'h0000_0002);
  endtask
  task t_fail;
    stall <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      rd_reg(`REG_STATUS);
      if (rd[1] === 1'b1) break;
    end
    chk("fail on late grant", rd[1], 1'b1);
    stall <= 1'b0;
    wr_reg(`REG_STATUS, 32'h0000_0002);
    rd_reg(`REG_STATUS);
    chk("fail cleared", rd[1], 1'b0);
  endtask
  // clock enable low must freeze the drum walk, high must let it run again
  task t_hold;
    logic [13:0] held;
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    held = daddr;
    repeat (40) @(posedge clk);
    chk("drum frozen", daddr, held);
    ce <= 1'b1;
    repeat (40) @(posedge clk);
    chk("drum resumed", daddr == held, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, stall} = 6'h00;
    ce = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    // band: control, X address, nine points, answer address per function
    for (int f = 0; f < 3; f++) begin
      mem_model_inst.rom[12*f] = (f == 2) ? 11'h425 : 11'h401;
      mem_model_inst.rom[12*f+1] = (f == 1) ? 11'h006 : 11'h005;
      for (int i = 0; i < 9; i++) mem_model_inst.rom[12*f+2+i] = 11'(100 * (i + 1));
      mem_model_inst.rom[12*f+11] = 11'(20 + f);
    end
    // three variables, Y address indexed: X, Y, Z words, 729 points, answer
    mem_model_inst.rom[36] = 11'h40B;
    mem_model_inst.rom[37] = 11'h005;
    mem_model_inst.rom[38] = 11'h006;
    mem_model_inst.rom[39] = 11'h009;
    for (int z = 0; z < 9; z++) begin
      for (int y = 0; y < 9; y++) begin
        for (int x = 0; x < 9; x++) begin
          mem_model_inst.rom[40 + x + 9*y + 81*z] = 11'(4*x + 30*y + 80*z);
        end
      end
    end
    mem_model_inst.rom[769] = 11'h01A;
    mem_model_inst.mem[8] = 24'h18_0000;
    mem_model_inst.mem[9] = 24'h34_0000;
    // low ten bits set so a wider argument copy would show
    mem_model_inst.mem[5] = 24'h28_03FF;
    mem_model_inst.mem[6] = 24'hA8_03FF;
    mem_model_inst.mem[7] = 24'h74_0000;
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_funcs();
    t_sweep();
    t_fail();
    t_hold();
    end_sim();
  end
endmodule // linear_function_interpolator_tb
